// *** bench/add_and_datapath_assertions.sv ***
// checker: port rules of the add/and datapath
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module add_and_checker (
	input wire logic core_clk_in, rst_in, insn_valid_in,
	input wire logic [13:0] insn_in,
	input wire logic [7:0] file_rdata_in, file_wdata_out, acc_out,
	input wire logic [6:0] file_addr_out,
	input wire logic file_we_out, carry_flag_out, digit_carry_flag_out, zero_flag_out,
	input wire logic exec_done_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// ==========================================================
	// recognised words, gated by valid
	wire al = insn_valid_in && insn_in[13:9] == 5'h1f;
	wire nl = insn_valid_in && insn_in[13:8] == 6'h39;
	wire af = insn_valid_in && insn_in[13:8] == 6'h07;
	wire nf = insn_valid_in && insn_in[13:8] == 6'h05;
	wire [7:0] b = insn_in[13] ? insn_in[7:0] : file_rdata_in; // operand
	// ==========================================================
	// reference values, rebuilt from the encodings
	wire [8:0] s = {1'b0, acc_out} + {1'b0, b}; // sum with carry out of bit 7
	wire [4:0] h = {1'b0, acc_out[3:0]} + {1'b0, b[3:0]}; // low nibble sum
	wire [7:0] res = file_we_out ? file_wdata_out : acc_out; // last result
	// ==========================================================
	// assertions
	a_add_sum: assert property ((al || af && !insn_in[7]) |=>
		acc_out == $past(s[7:0]))
		else $error("bad sum");
	a_and_result: assert property ((nl || nf && !insn_in[7]) |=>
		acc_out == $past(acc_out & b))
		else $error("bad and");
	a_carry_out: assert property ((al || af) |=> carry_flag_out == $past(s[8]))
		else $error("bad carry");
	a_digit_carry: assert property ((al || af) |=> digit_carry_flag_out == $past(h[4]))
		else $error("bad digit carry");
	a_and_flags: assert property ((nl || nf) |=>
		$stable({carry_flag_out, digit_carry_flag_out}))
		else $error("and moved carry");
	a_zero_flag: assert property (exec_done_out |-> zero_flag_out == (res == 8'h00))
		else $error("bad zero");
	a_file_dest: assert property ((af || nf) && insn_in[7] |=>
		file_we_out && $stable(acc_out))
		else $error("bad file write");
	a_acc_dest: assert property ((af || nf) && !insn_in[7] |=> !file_we_out)
		else $error("file written");
	a_idle_hold: assert property (!(al || nl || af || nf) |=>
		!exec_done_out && !file_we_out &&
		$stable({acc_out, carry_flag_out, digit_carry_flag_out, zero_flag_out}))
		else $error("idle word changed state");
endmodule

// *** bench/file_array_model.sv ***
// file register array: combinational read, write on the strobe
// assumes a one-cycle write strobe from the datapath
`timescale 1ns/1ps
module file_array_model (
	input wire logic core_clk_in, we_in,
	input wire logic [6:0] waddr_in, raddr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [128];
	// known contents at time zero, mirrored in the bench's reference
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
	// combinational read of the addressed register
	assign rdata_out = mem[raddr_in];
	// write lands one edge late, so the bench leaves a gap between file ops
	always @(posedge core_clk_in) if (we_in) mem[waddr_in] <= wdata_in;
endmodule

// *** bench/test_add_and_datapath.sv ***
// bench: random add/and instructions against a reference model
// assumes the checker and file array model are compiled first
`timescale 1ns/1ps
module test_add_and_datapath;
	logic core_clk_in = 0, rst_in = 1, insn_valid_in = 0;
	logic [13:0] insn_in = '0;
	logic [7:0] file_rdata_in, file_wdata_out, acc_out;
	logic [6:0] file_addr_out;
	logic file_we_out, carry_flag_out, digit_carry_flag_out, zero_flag_out, exec_done_out;
	int fail_count = 0, check_count = 0, a = 0, r, f, res;
	bit c, dc, z;
	int m [128];
	// ==========================================================
	// clock: 20 ns period
	initial forever #10 core_clk_in = ~core_clk_in;
	// ==========================================================
	// design and the file array at its far side
	add_and_datapath dut (.*);
	file_array_model files (.core_clk_in, .we_in(file_we_out), .waddr_in(file_addr_out),
		.raddr_in(insn_in[6:0]), .wdata_in(file_wdata_out), .rdata_out(file_rdata_in));
	// ==========================================================
	// compare and report
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ==========================================================
	// stimulus: one instruction every other cycle, reference model alongside
	initial
	begin
		for (int i = 0; i < 128; i++) m[i] = (i * 37) % 256;
		repeat (20) @(posedge core_clk_in);
		rst_in <= 0;
		void'($urandom(48));
		for (int n = 0; n < 600; n++)
		begin
			// mid-run reset: outputs clear, file contents survive
			if (n == 300)
			begin
				@(posedge core_clk_in);
				rst_in <= 1;
				repeat (2) @(posedge core_clk_in);
				#1;
				chk("rst acc", 16'h0, 16'({acc_out, exec_done_out, file_we_out}));
				chk("rst flags", 16'h0, 16'({carry_flag_out, digit_carry_flag_out, zero_flag_out}));
				chk("rst file", 16'h0, 16'({file_addr_out, file_wdata_out}));
				@(posedge core_clk_in);
				rst_in <= 0;
				a = 0;
				c = 0;
				dc = 0;
				z = 0;
			end
			r = $urandom % 6;
			@(posedge core_clk_in);
			insn_in <= {r == 0 ? {5'h1f, 1'($urandom)} : r == 1 ? 6'h39 : r == 2 ? 6'h07 :
				r == 3 ? 6'h05 : r == 4 ? 6'h08 : 6'h07, 8'($urandom)};
			// r = 5 offers a recognised add-file word with valid held low
			insn_valid_in <= r != 5;
			@(posedge core_clk_in);
			insn_valid_in <= 0;
			f = r > 1 ? m[insn_in[6:0]] : insn_in[7:0];
			if (r < 4)
			begin
				res = r % 2 ? a & f : a + f;
				if (r % 2 == 0)
				begin
					c = res > 255;
					dc = a % 16 + f % 16 > 15;
				end
				res = res % 256;
				z = res == 0;
				if (r > 1 && insn_in[7])
					m[insn_in[6:0]] = res;
				else
					a = res;
			end
			#1;
			chk("acc", 16'(a), 16'(acc_out));
			chk("flags", {c, dc, z}, {carry_flag_out, digit_carry_flag_out, zero_flag_out});
			chk("done", 16'(r < 4), 16'(exec_done_out));
			chk("write", r > 1 && r < 4 && insn_in[7], file_we_out);
			if (file_we_out === 1'b1)
				chk("file", {insn_in[6:0], 8'(m[insn_in[6:0]])}, {file_addr_out, file_wdata_out});
		end
		give_verdict();
	end
endmodule
bind add_and_datapath add_and_checker chk_i (.*);

// *** rtl/add_and_datapath.sv ***
// add_and_datapath: executes the add/and literal and file instructions
// assumes the decoder presents one instruction per valid cycle and the file
// array returns the addressed register's value combinationally with it
`timescale 1ns/1ps

module add_and_datapath
	import alu_exec_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// instruction from the decoder
	input wire logic insn_valid_in,
	input wire logic [alu_exec_pkg::INSN_W-1:0] insn_in,
	// file register read data for the addressed register
	input wire logic [alu_exec_pkg::DATA_W-1:0] file_rdata_in,
	// file register write port
	output logic file_we_out,
	output logic [alu_exec_pkg::ADDR_W-1:0] file_addr_out,
	output logic [alu_exec_pkg::DATA_W-1:0] file_wdata_out,
	// architectural state
	output logic [alu_exec_pkg::DATA_W-1:0] acc_out,
	output logic carry_flag_out,
	output logic digit_carry_flag_out,
	output logic zero_flag_out,
	// one-cycle pulse when an instruction was executed
	output logic exec_done_out
);
	import alu_exec_pkg::*;

	// ==========================================================
	// state
	// architectural registers, all cleared by the synchronous reset
	logic [DATA_W-1:0] acc; // accumulator
	logic carry_flag; // carry out of bit 7 of the last add
	logic digit_carry_flag; // carry out of bit 3 of the last add
	logic zero_flag; // last add or and gave zero
	// write port registers, so the file array sees clean timing
	logic file_we; // one-cycle write strobe
	logic [ADDR_W-1:0] file_addr; // held until the next file write
	logic [DATA_W-1:0] file_wdata; // held until the next file write
	logic exec_done; // one-cycle execute pulse

	// next values, all built in the single always_comb below
	logic [DATA_W-1:0] next_acc;
	logic next_carry_flag;
	logic next_digit_carry_flag;
	logic next_zero_flag;
	logic next_file_we;
	logic [ADDR_W-1:0] next_file_addr;
	logic [DATA_W-1:0] next_file_wdata;
	logic next_exec_done;

	// combinational datapath nets
	alu_op_t op; // decoded operation
	logic [DATA_W-1:0] operand; // literal or file value
	logic [DATA_W-1:0] result; // add or and result before the destination select
	logic [DATA_W:0] sum_full; // sum with carry out of bit 7
	logic [NIBBLE_W:0] low_sum; // low nibble sum with carry out of bit 3

	// ==========================================================
	// decode: unmatched opcodes give op_none so the block ignores them
	function automatic alu_op_t decode(input logic [INSN_W-1:0] insn);
		alu_op_t d;
		d = op_none;
		if (insn[TOP_HI:TOP_LO] == TOP_LITERAL)
		begin
			// literal group: the lowest field bit is a don't-care for the add
			if (insn[OPF_HI:OPF_LO+1] == OPF_ADD_LITERAL)
				d = add_literal_op;
			else if (insn[OPF_HI:OPF_LO] == OPF_AND_LITERAL)
				d = and_literal_op;
		end
		else if (insn[TOP_HI:TOP_LO] == TOP_BYTE_FILE)
		begin
			// byte-oriented file group
			if (insn[OPF_HI:OPF_LO] == OPF_ADD_FILE)
				d = add_file_op;
			else if (insn[OPF_HI:OPF_LO] == OPF_AND_FILE)
				d = and_file_op;
		end
		return d;
	endfunction

	// ==========================================================
	// operation classes: is_literal is needed in more than one place,
	// so each test is written once here and cannot drift between copies
	function automatic logic is_literal(input alu_op_t o);
		return (o == add_literal_op) || (o == and_literal_op);
	endfunction

	function automatic logic is_file(input alu_op_t o);
		return (o == add_file_op) || (o == and_file_op);
	endfunction

	function automatic logic is_add(input alu_op_t o);
		return (o == add_literal_op) || (o == add_file_op);
	endfunction

	// zero test on a result, shared by the add and the and forms
	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		return (v == '0);
	endfunction

	// ==========================================================
	// datapath and next state
	always_comb
	begin
		// a word counts only while the decoder marks it valid
		op = insn_valid_in ? decode(insn_in) : op_none;
		// literal ops take the immediate, file ops the addressed register
		if (is_literal(op))
			operand = insn_in[LIT_HI:0];
		else
			operand = file_rdata_in;
		// one shared adder serves both add forms
		sum_full = {1'b0, acc} + {1'b0, operand};
		low_sum = {1'b0, acc[NIBBLE_W-1:0]} + {1'b0, operand[NIBBLE_W-1:0]};
		// the sum is kept only for the add forms
		if (is_add(op))
			result = sum_full[DATA_W-1:0];
		else
			result = acc & operand;

		// defaults: every register holds and both pulses drop
		next_acc = acc;
		next_carry_flag = carry_flag;
		next_digit_carry_flag = digit_carry_flag;
		next_zero_flag = zero_flag;
		next_file_we = 1'b0;
		next_file_addr = file_addr;
		next_file_wdata = file_wdata;
		next_exec_done = 1'b0;

		case (op)
			add_literal_op, add_file_op:
			begin
				// adds update all three flags
				next_carry_flag = sum_full[DATA_W];
				next_digit_carry_flag = low_sum[NIBBLE_W];
				next_zero_flag = is_zero(result);
				next_exec_done = 1'b1;
			end
			and_literal_op, and_file_op:
			begin
				// ands leave carry and digit carry alone
				next_zero_flag = is_zero(result);
				next_exec_done = 1'b1;
			end
			default:
			begin
				// idle or unrecognised word: no state change, no pulse
				next_exec_done = 1'b0;
			end
		endcase

		// destination select
		// literal forms always write the accumulator
		if (is_literal(op))
			next_acc = result;
		else if (is_file(op))
		begin
			// the destination bit picks the file register or the accumulator
			if (insn_in[DEST_BIT])
			begin
				// write back to file, accumulator kept
				next_file_we = 1'b1;
				next_file_addr = insn_in[ADDR_HI:0];
				next_file_wdata = result;
			end
			else
				next_acc = result;
		end
	end

	// ==========================================================
	// registers: the file write lands one cycle after execution, so a
	// decoder issuing back to back must forward file_wdata itself
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			// clear all state; no write is left pending across a reset
			acc <= ACC_RESET;
			carry_flag <= FLAG_RESET;
			digit_carry_flag <= FLAG_RESET;
			zero_flag <= FLAG_RESET;
			file_we <= 1'b0;
			file_addr <= '0;
			file_wdata <= '0;
			exec_done <= 1'b0;
		end
		else
		begin
			// run: register the values the datapath computed
			acc <= next_acc;
			carry_flag <= next_carry_flag;
			digit_carry_flag <= next_digit_carry_flag;
			zero_flag <= next_zero_flag;
			file_we <= next_file_we;
			file_addr <= next_file_addr;
			file_wdata <= next_file_wdata;
			exec_done <= next_exec_done;
		end
	end

	// ==========================================================
	// outputs: straight from the flip-flops, no logic after them
	assign acc_out = acc;
	assign carry_flag_out = carry_flag;
	assign digit_carry_flag_out = digit_carry_flag;
	assign zero_flag_out = zero_flag;
	assign file_we_out = file_we;
	assign file_addr_out = file_addr;
	assign file_wdata_out = file_wdata;
	assign exec_done_out = exec_done;

endmodule

// *** rtl/alu_exec_pkg.sv ***
// alu_exec_pkg: opcode fields, widths and reset values for the add/and datapath
// assumes a 14-bit instruction word, 8-bit data and 7-bit file addresses
package alu_exec_pkg;

	// ==========================================================
	// widths
	localparam int INSN_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;

	// ==========================================================
	// instruction field positions
	localparam int TOP_HI = 13;
	localparam int TOP_LO = 12;
	localparam int OPF_HI = 11;
	localparam int OPF_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int ADDR_HI = 6;
	localparam int LIT_HI = 7;

	// ==========================================================
	// opcode encodings
	localparam logic [1:0] TOP_LITERAL = 2'h3;
	localparam logic [1:0] TOP_BYTE_FILE = 2'h0;
	localparam logic [2:0] OPF_ADD_LITERAL = 3'h7; // 111x, low bit ignored
	localparam logic [3:0] OPF_AND_LITERAL = 4'h9;
	localparam logic [3:0] OPF_ADD_FILE = 4'h7;
	localparam logic [3:0] OPF_AND_FILE = 4'h5;

	// ==========================================================
	// reset values and nibble width
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic FLAG_RESET = 1'b0;
	localparam int NIBBLE_W = 4;

	// decoded operation
	typedef enum logic [2:0] {
		op_none,
		add_literal_op,
		and_literal_op,
		add_file_op,
		and_file_op
	} alu_op_t;

endpackage
